// ===== ook_pkg.sv
// constants and types for the ook packet encoder
package ook_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int RATE_DEF_BPS = 4800;
    localparam int RATE_MAX_BPS = 40000;
    localparam int RATE_MIN_BPS = 500;
    localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / RATE_DEF_BPS - 1);
    localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / RATE_MAX_BPS - 1);
    localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / RATE_MIN_BPS - 1);
    // ----------------------------------------
    // register indices, byte address is index * 4
    // ----------------------------------------
    localparam int NCFG = 10;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CODING = 4'h1;
    localparam logic [3:0] REG_COUNTS = 4'h2;
    localparam logic [3:0] REG_PKT = 4'h3;
    localparam logic [3:0] REG_SYNC = 4'h4;
    localparam logic [3:0] REG_ID = 4'h5;
    localparam logic [3:0] REG_SIZES = 4'h6;
    localparam logic [3:0] REG_STOP = 4'h7;
    localparam logic [3:0] REG_KEYS = 4'h8;
    localparam logic [3:0] REG_RATE = 4'h9;
    localparam logic [3:0] REG_STATUS = 4'ha;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int START_BIT = 0;
    localparam int KEYMTX_BIT = 1;
    localparam int PREAA_BIT = 2;
    localparam int PREGRP_BIT = 3;
    localparam int POWER_LSB = 4;
    localparam int CPB_LSB = 0;
    localparam int ONE_LSB = 8;
    localparam int ZERO_LSB = 16;
    localparam int GAP_LSB = 0;
    localparam int GROUP_LSB = 16;
    localparam int PKTCNT_LSB = 0;
    localparam int PRELEN_LSB = 16;
    localparam int SYNCSZ_LSB = 0;
    localparam int IDSZ_LSB = 8;
    localparam int STOPSZ_LSB = 16;
    localparam int KEYSZ_LSB = 24;
    localparam int ST_FIELD_LSB = 4;
    localparam int ST_PKT_LSB = 8;
    localparam int ST_GRP_LSB = 20;
    // ----------------------------------------
    // reset values and writable bits
    // ----------------------------------------
    localparam logic [31:0] REG_RST [NCFG] = '{32'h0000_00d0, 32'h0008_0e04, 32'h0000_0000,
        32'h0000_0002, 32'h8000_0000, 32'h0000_0000, 32'h0400_0820, 32'h0000_0000,
        32'h0804_0201, {16'h0000, DIV_DEF}};
    localparam logic [31:0] REG_MASK [NCFG] = '{32'h0000_00fe, 32'h00ff_ff0f, 32'h01ff_01ff,
        32'h01ff_01ff, 32'hffff_ffff, 32'hffff_ffff, 32'h0f1f_3f3f, 32'h0000_ffff,
        32'hffff_ffff, 32'h0000_ffff};
    // ----------------------------------------
    // limits and patterns
    // ----------------------------------------
    localparam logic [3:0] MAX_POWER = 4'hd;
    localparam logic [3:0] MAX_CPB = 4'h8;
    localparam logic [11:0] MAX_SYNC = 12'h020;
    localparam logic [11:0] MAX_ID = 12'h020;
    localparam logic [11:0] MAX_STOP = 12'h010;
    localparam logic [11:0] MAX_KEY = 12'h008;
    localparam logic [8:0] MAX_COUNT = 9'h100;
    localparam logic [7:0] PRE_BYTE_A = 8'h55;
    localparam logic [7:0] PRE_BYTE_B = 8'haa;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GAP} state_t;
    typedef enum logic [2:0] {F_PRE, F_SYNC, F_ID, F_KEY, F_STOP, F_DONE} field_t;
endpackage

// ===== ook_packet_encoder.sv
// ook packet encoder with avalon-mm configuration slave
// Functional notes
// - idle gap of 0..511 symbols between transmissions
// - no groups: gap between every packet
// - groups: packets back to back, gap between groups
// - each bit is one to eight chips
// - one chip nrz, two manchester, more pwm
// - logic one sends one-pattern, default 1110
// - logic zero sends zero-pattern, default 1000
// - preamble 0..511 bytes, zero omits it
// - preamble byte 0x55 or 0xaa, default 0x55
// - preamble every packet or first of group
// - sync word 0..32 bits, default 0x80000000
// - identifier field 1..32 bits, programmable value
// - stop bits 0..16, programmable, default zero
// - keys scanned as matrix or direct inputs
// - key code 0..8 bits from pressed key
// - power step 0..13 dbm, 1 dbm steps
// - group count zero disables grouping
// - packet count 1..256, preset or per group
// - symbol rate 0.5..40 kbps
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
module ook_packet_encoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // keys
    input wire logic [3:0] keyIn,
    output logic [1:0] scanOut,
    // transmitter
    output logic ookOut,
    output logic txActive,
    output logic [3:0] powerStep
);
    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [31:0] cfg_q [ook_pkg::NCFG];
    logic [31:0] cfg_d [ook_pkg::NCFG];
    logic [31:0] rd_q, rd_d;
    logic wait_q, wait_d;
    logic startWr;
    logic [3:0] regIdx;
    logic [31:0] laneMask;
    logic [31:0] statusWord;

    ook_pkg::state_t state_q, state_d;
    ook_pkg::field_t field_q, field_d;
    logic [11:0] bitCnt_q, bitCnt_d;
    logic [2:0] chipCnt_q, chipCnt_d;
    logic [8:0] pktCnt_q, pktCnt_d, grpCnt_q, grpCnt_d, gapCnt_q, gapCnt_d;
    logic [15:0] divCnt_q, divCnt_d;
    logic [7:0] keyCode_q, keyCode_d;
    logic [1:0] scan_q, scan_d;
    logic ook_q, ook_d, active_q, active_d;
    logic [3:0] power_q, power_d;

    assign regIdx = avsAddress[5:2];
    assign laneMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                       {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
    assign statusWord = {3'h0, grpCnt_q, 3'h0, pktCnt_q, 1'b0, field_q, 3'h0, active_q};

    always_comb begin
        wait_d = 1'b1;
        rd_d = rd_q;
        startWr = 1'b0;
        for (int r = 0; r < ook_pkg::NCFG; r++) begin
            cfg_d[r] = cfg_q[r];
        end
        // two-cycle answer keeps the read mux off the bus path
        if ((avsRead || avsWrite) && wait_q) begin
            wait_d = 1'b0;
            rd_d = 32'h0000_0000;
            if (avsAddress[7:6] == 2'h0 && regIdx == ook_pkg::REG_STATUS) begin
                rd_d = statusWord;
            end else if (avsAddress[7:6] == 2'h0 && regIdx < 4'(ook_pkg::NCFG)) begin
                rd_d = cfg_q[regIdx];
            end
        end
        if (avsWrite && !wait_q && avsAddress[7:6] == 2'h0 && regIdx < 4'(ook_pkg::NCFG)) begin
            cfg_d[regIdx] = (cfg_q[regIdx] & ~(ook_pkg::REG_MASK[regIdx] & laneMask))
                | (avsWriteData & ook_pkg::REG_MASK[regIdx] & laneMask);
            startWr = regIdx == ook_pkg::REG_CTRL && avsByteEnable[0]
                && avsWriteData[ook_pkg::START_BIT];
        end
    end

    for (genvar r = 0; r < ook_pkg::NCFG; r++) begin : g_cfg
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cfg_q[r] <= ook_pkg::REG_RST[r];
            end else begin
                cfg_q[r] <= cfg_d[r];
            end
        end
    end

    // ----------------------------------------
    // decoded settings
    // ----------------------------------------
    logic keyMatrix, preAa, preGroupOnly, grouped;
    logic [3:0] powerSet, cpbRaw, cpbEff;
    logic [2:0] cpbTop;
    logic [7:0] onePat, zeroPat, preByte;
    logic [8:0] gapLen, groupCount, pktCountRaw, pktTarget, grpTarget, preLen;
    logic [5:0] syncSize, idSize;
    logic [4:0] stopSize;
    logic [3:0] keySize;
    logic [15:0] divRaw, divEff;

    assign keyMatrix = cfg_q[ook_pkg::REG_CTRL][ook_pkg::KEYMTX_BIT];
    assign preAa = cfg_q[ook_pkg::REG_CTRL][ook_pkg::PREAA_BIT];
    assign preGroupOnly = cfg_q[ook_pkg::REG_CTRL][ook_pkg::PREGRP_BIT];
    assign powerSet = cfg_q[ook_pkg::REG_CTRL][ook_pkg::POWER_LSB +: 4];
    assign cpbRaw = cfg_q[ook_pkg::REG_CODING][ook_pkg::CPB_LSB +: 4];
    assign onePat = cfg_q[ook_pkg::REG_CODING][ook_pkg::ONE_LSB +: 8];
    assign zeroPat = cfg_q[ook_pkg::REG_CODING][ook_pkg::ZERO_LSB +: 8];
    assign gapLen = cfg_q[ook_pkg::REG_COUNTS][ook_pkg::GAP_LSB +: 9];
    assign groupCount = cfg_q[ook_pkg::REG_COUNTS][ook_pkg::GROUP_LSB +: 9];
    assign pktCountRaw = cfg_q[ook_pkg::REG_PKT][ook_pkg::PKTCNT_LSB +: 9];
    assign preLen = cfg_q[ook_pkg::REG_PKT][ook_pkg::PRELEN_LSB +: 9];
    assign syncSize = cfg_q[ook_pkg::REG_SIZES][ook_pkg::SYNCSZ_LSB +: 6];
    assign idSize = cfg_q[ook_pkg::REG_SIZES][ook_pkg::IDSZ_LSB +: 6];
    assign stopSize = cfg_q[ook_pkg::REG_SIZES][ook_pkg::STOPSZ_LSB +: 5];
    assign keySize = cfg_q[ook_pkg::REG_SIZES][ook_pkg::KEYSZ_LSB +: 4];
    assign divRaw = cfg_q[ook_pkg::REG_RATE][15:0];
    // out-of-range settings are clamped rather than refused
    assign cpbEff = cpbRaw == 4'h0 ? 4'h1 : (cpbRaw > ook_pkg::MAX_CPB ? ook_pkg::MAX_CPB : cpbRaw);
    assign cpbTop = 3'(cpbEff - 4'h1);
    assign preByte = preAa ? ook_pkg::PRE_BYTE_B : ook_pkg::PRE_BYTE_A;
    assign grouped = groupCount != 9'h000;
    assign pktTarget = pktCountRaw == 9'h000 ? 9'h001 : (pktCountRaw > ook_pkg::MAX_COUNT ? ook_pkg::MAX_COUNT : pktCountRaw);
    assign grpTarget = groupCount > ook_pkg::MAX_COUNT ? ook_pkg::MAX_COUNT : groupCount;
    assign divEff = divRaw < ook_pkg::DIV_MIN ? ook_pkg::DIV_MIN
        : (divRaw > ook_pkg::DIV_MAX ? ook_pkg::DIV_MAX : divRaw);

    // ----------------------------------------
    // field helpers
    // ----------------------------------------
    function automatic logic [11:0] lim(logic [11:0] v, logic [11:0] m);
        return v > m ? m : v;
    endfunction

    function automatic logic [11:0] fieldLen(ook_pkg::field_t f, logic skipPre);
        unique case (f)
            ook_pkg::F_PRE: fieldLen = skipPre ? 12'h000 : {preLen, 3'h0};
            ook_pkg::F_SYNC: fieldLen = lim(12'(syncSize), ook_pkg::MAX_SYNC);
            ook_pkg::F_ID: fieldLen = idSize == 6'h00 ? 12'h001 : lim(12'(idSize), ook_pkg::MAX_ID);
            ook_pkg::F_KEY: fieldLen = lim(12'(keySize), ook_pkg::MAX_KEY);
            ook_pkg::F_STOP: fieldLen = lim(12'(stopSize), ook_pkg::MAX_STOP);
            default: fieldLen = 12'h000;
        endcase
    endfunction

    // skip empty fields; the identifier is never empty so a packet always ends
    function automatic ook_pkg::field_t nextField(ook_pkg::field_t f, logic skipPre);
        ook_pkg::field_t g;
        g = f;
        for (int k = 0; k < 5; k++) begin
            if (g != ook_pkg::F_DONE && fieldLen(g, skipPre) == 12'h000) begin
                g = ook_pkg::field_t'(g + 3'h1);
            end
        end
        return g;
    endfunction

    function automatic logic [2:0] firstSet(logic [3:0] v);
        firstSet = 3'h0;
        for (int k = 3; k >= 0; k--) begin
            if (v[k]) begin
                firstSet = {1'b1, 2'(k)};
            end
        end
    endfunction

    // ----------------------------------------
    // keys
    // ----------------------------------------
    logic [2:0] directPick, rowPick;
    logic keyHit;
    logic [1:0] keyIdx;
    assign directPick = firstSet(keyIn);
    assign rowPick = firstSet({2'h0, keyIn[1:0]});
    always_comb begin
        scan_d = keyMatrix ? (scan_q == 2'h1 ? 2'h2 : 2'h1) : 2'h0;
        if (keyMatrix) begin
            keyHit = rowPick[2] && scan_q != 2'h0;
            keyIdx = {scan_q[1], rowPick[0]};
        end else begin
            keyHit = directPick[2];
            keyIdx = directPick[1:0];
        end
    end

    // ----------------------------------------
    // packet sequencer
    // ----------------------------------------
    logic tick, bitNow, chipOne, chipZero, pktEnd, lastPkt, startPkt, startSkip;
    logic [8:0] pktNext, grpNext;
    ook_pkg::field_t nf;
    assign tick = divCnt_q == 16'h0000;
    assign bitNow = field_q == ook_pkg::F_PRE ? preByte[bitCnt_q[2:0]]
        : field_q == ook_pkg::F_SYNC ? cfg_q[ook_pkg::REG_SYNC][bitCnt_q[4:0]]
        : field_q == ook_pkg::F_ID ? cfg_q[ook_pkg::REG_ID][bitCnt_q[4:0]]
        : field_q == ook_pkg::F_KEY ? keyCode_q[bitCnt_q[2:0]]
        : cfg_q[ook_pkg::REG_STOP][bitCnt_q[3:0]];
    assign chipOne = onePat[chipCnt_q];
    assign chipZero = zeroPat[chipCnt_q];
    assign pktNext = pktCnt_q + 9'h001;
    assign grpNext = grpCnt_q + 9'h001;
    assign lastPkt = pktNext >= pktTarget;
    // a process, not an assign, so config reads inside the function wake it
    always_comb begin
        nf = nextField(ook_pkg::field_t'(field_q + 3'h1), 1'b0);
    end
    assign pktEnd = state_q == ook_pkg::ST_SEND && chipCnt_q == 3'h0 && bitCnt_q == 12'h000
        && nf == ook_pkg::F_DONE;

    always_comb begin
        state_d = state_q;
        field_d = field_q;
        bitCnt_d = bitCnt_q;
        chipCnt_d = chipCnt_q;
        pktCnt_d = pktCnt_q;
        grpCnt_d = grpCnt_q;
        gapCnt_d = gapCnt_q;
        keyCode_d = keyCode_q;
        ook_d = ook_q;
        startPkt = 1'b0;
        startSkip = 1'b0;
        divCnt_d = tick ? divEff : divCnt_q - 16'h0001;
        if (tick) begin
            ook_d = state_q == ook_pkg::ST_SEND && (bitNow ? chipOne : chipZero);
        end
        unique case (state_q)
            ook_pkg::ST_IDLE: begin
                if (keyHit || startWr) begin
                    keyCode_d = cfg_q[ook_pkg::REG_KEYS][{keyIdx, 3'h0} +: 8];
                    pktCnt_d = 9'h000;
                    grpCnt_d = 9'h000;
                    startPkt = 1'b1;
                end
            end
            ook_pkg::ST_SEND: begin
                if (tick && chipCnt_q != 3'h0) begin
                    chipCnt_d = chipCnt_q - 3'h1;
                end else if (tick && bitCnt_q != 12'h000) begin
                    chipCnt_d = cpbTop;
                    bitCnt_d = bitCnt_q - 12'h001;
                end else if (tick && !pktEnd) begin
                    chipCnt_d = cpbTop;
                    field_d = nf;
                    bitCnt_d = fieldLen(nf, 1'b0) - 12'h001;
                end else if (tick) begin
                    if (!lastPkt) begin
                        pktCnt_d = pktNext;
                        if (grouped || gapLen == 9'h000) begin
                            startPkt = 1'b1;
                            startSkip = grouped && preGroupOnly;
                        end else begin
                            state_d = ook_pkg::ST_GAP;
                            gapCnt_d = gapLen;
                        end
                    end else if (grouped && grpNext < grpTarget) begin
                        pktCnt_d = 9'h000;
                        grpCnt_d = grpNext;
                        state_d = ook_pkg::ST_GAP;
                        gapCnt_d = gapLen;
                        startPkt = gapLen == 9'h000;
                    end else begin
                        state_d = ook_pkg::ST_IDLE;
                        field_d = ook_pkg::F_DONE;
                    end
                end
            end
            ook_pkg::ST_GAP: begin
                if (tick && gapCnt_q <= 9'h001) begin
                    startPkt = 1'b1;
                end else if (tick) begin
                    gapCnt_d = gapCnt_q - 9'h001;
                end
            end
            default: state_d = ook_pkg::ST_IDLE;
        endcase
        if (startPkt) begin
            state_d = ook_pkg::ST_SEND;
            field_d = nextField(ook_pkg::F_PRE, startSkip);
            bitCnt_d = fieldLen(field_d, startSkip) - 12'h001;
            chipCnt_d = cpbTop;
        end
    end

    assign active_d = state_d != ook_pkg::ST_IDLE;
    assign power_d = powerSet > ook_pkg::MAX_POWER ? ook_pkg::MAX_POWER : powerSet;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ook_pkg::ST_IDLE;
            field_q <= ook_pkg::F_DONE;
            bitCnt_q <= 12'h000;
            chipCnt_q <= 3'h0;
            pktCnt_q <= 9'h000;
            grpCnt_q <= 9'h000;
            gapCnt_q <= 9'h000;
            divCnt_q <= 16'h0000;
            keyCode_q <= 8'h00;
            scan_q <= 2'h0;
            ook_q <= 1'b0;
            active_q <= 1'b0;
            power_q <= 4'h0;
            rd_q <= 32'h0000_0000;
            wait_q <= 1'b1;
        end else begin
            state_q <= state_d;
            field_q <= field_d;
            bitCnt_q <= bitCnt_d;
            chipCnt_q <= chipCnt_d;
            pktCnt_q <= pktCnt_d;
            grpCnt_q <= grpCnt_d;
            gapCnt_q <= gapCnt_d;
            divCnt_q <= divCnt_d;
            keyCode_q <= keyCode_d;
            scan_q <= scan_d;
            ook_q <= ook_d;
            active_q <= active_d;
            power_q <= power_d;
            rd_q <= rd_d;
            wait_q <= wait_d;
        end
    end

    assign avsReadData = rd_q;
    assign avsWaitRequest = wait_q;
    assign scanOut = scan_q;
    assign ookOut = ook_q;
    assign txActive = active_q;
    assign powerStep = power_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_gapQuiet;
        state_q == ook_pkg::ST_GAP && tick |=> !ookOut;
    endproperty
    a_gapQuiet: assert property (p_gapQuiet) else $error("carrier on during gap");
    property p_gapLoad;
        tick && pktEnd && !grouped && !lastPkt && gapLen != 9'h000
            |=> state_q == ook_pkg::ST_GAP && gapCnt_q == $past(gapLen);
    endproperty
    a_gapLoad: assert property (p_gapLoad) else $error("packet gap not applied");
    property p_groupTight;
        tick && pktEnd && grouped && !lastPkt |=> state_q == ook_pkg::ST_SEND;
    endproperty
    a_groupTight: assert property (p_groupTight) else $error("gap inside group");
    property p_chipRange;
        state_q == ook_pkg::ST_SEND |-> chipCnt_q <= cpbTop;
    endproperty
    a_chipRange: assert property (p_chipRange) else $error("chip index past bit");
    property p_onePat;
        tick && state_q == ook_pkg::ST_SEND && bitNow |=> ookOut == $past(chipOne);
    endproperty
    a_onePat: assert property (p_onePat) else $error("one pattern chip wrong");
    property p_zeroPat;
        tick && state_q == ook_pkg::ST_SEND && !bitNow |=> ookOut == $past(chipZero);
    endproperty
    a_zeroPat: assert property (p_zeroPat) else $error("zero pattern chip wrong");
    property p_noPreamble;
        state_q == ook_pkg::ST_IDLE && preLen == 9'h000 && (keyHit || startWr)
            |=> field_q != ook_pkg::F_PRE;
    endproperty
    a_noPreamble: assert property (p_noPreamble) else $error("empty preamble sent");
    property p_powerCap;
        powerStep <= ook_pkg::MAX_POWER;
    endproperty
    a_powerCap: assert property (p_powerCap) else $error("power step above cap");
    property p_bitStep;
        tick && state_q == ook_pkg::ST_SEND && chipCnt_q == 3'h0 && bitCnt_q != 12'h000
            |=> bitCnt_q == $past(bitCnt_q) - 12'h001 && chipCnt_q == cpbTop;
    endproperty
    a_bitStep: assert property (p_bitStep) else $error("bit order broken");
    property p_busAnswer;
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest ##1 avsWaitRequest;
    endproperty
    a_busAnswer: assert property (p_busAnswer) else $error("bus answer late");
    c_groupGap: cover property (grouped && state_q == ook_pkg::ST_GAP);
    c_preamble: cover property (field_q == ook_pkg::F_PRE && tick);
    c_matrixKey: cover property (keyMatrix && keyHit && state_q == ook_pkg::ST_IDLE);
endmodule

// ===== ook_rx_model.sv
// far-side receiver model: recovers one chip per symbol from the carrier key
`timescale 1ns/10ps
module ook_rx_model #(
    parameter int SYM = 625
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // air side
    input wire logic ookOut,
    input wire logic txActive,
    // recovered chips
    output logic chipValid,
    output logic chipBit
);
    logic lastChip;
    // frame found on first carrier-on; mid-symbol sampling avoids edge races
    always begin
        @(posedge clk);
        chipValid <= 1'b0;
        if (!rst && txActive === 1'b1 && ookOut === 1'b1) begin
            lastChip = 1'b0;
            while (!lastChip) begin
                // busy falls as the final chip starts, so that chip is still taken
                lastChip = txActive !== 1'b1;
                repeat (SYM / 2) @(posedge clk);
                chipBit <= ookOut;
                chipValid <= 1'b1;
                @(posedge clk);
                chipValid <= 1'b0;
                repeat (SYM - SYM / 2 - 1) @(posedge clk);
            end
        end
    end
endmodule

// ===== ook_packet_encoder_test.sv
// self-checking bench for the ook packet encoder
`timescale 1ns/10ps
module ook_packet_encoder_test;
    logic clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
    logic [7:0] avsAddress = 8'h00;
    logic [31:0] avsWriteData = 32'h0, avsReadData, seed = 32'h8b172e77, idVal;
    logic [3:0] avsByteEnable = 4'hf, keyIn = 4'h0, powerStep;
    logic [1:0] scanOut;
    logic avsWaitRequest, ookOut, txActive, chipValid, chipBit;
    logic expQ[$];
    logic [31:0] readQ[$];
    int errorCnt = 0, samplesChecked = 0;
    always #20 clk = ~clk;
    ook_packet_encoder DUT (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .keyIn(keyIn),
        .scanOut(scanOut), .ookOut(ookOut), .txActive(txActive), .powerStep(powerStep));
    ook_rx_model #(.SYM(625)) rx (.clk(clk), .rst(rst), .ookOut(ookOut), .txActive(txActive),
        .chipValid(chipValid), .chipBit(chipBit));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] regAddr(input logic [3:0] r);
        return {2'h0, r, 2'h0};
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finishTest();
        if (errorCnt == 0 && samplesChecked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // waits up to 50 clocks for the answer, then counts an error and ends the run
    task automatic bus(input logic wr, input logic [3:0] r, input logic [31:0] d);
        int n;
        n = 0;
        avsAddress <= regAddr(r);
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= d;
        if (!wr) readQ.push_back(d);
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (n >= 50) begin
            errorCnt++;
            finishTest();
        end
        @(posedge clk);
    endtask
    task automatic push(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) expQ.push_back(v[i]);
    endtask
    // cpb 1 tail: sync 1001, id 1, key 01, stop 01
    task automatic pushTail();
        push(32'h9, 4);
        push(32'h1, 1);
        push(32'h1, 2);
        push(32'h1, 2);
    endtask
    // start by ctrl write or a one-clock key press
    task automatic runTx(input logic [31:0] ctrl, input logic [3:0] key);
        int n;
        bus(1'b1, ook_pkg::REG_CTRL, ctrl);
        keyIn <= key;
        @(posedge clk);
        keyIn <= 4'h0;
        @(posedge clk);
        chk(txActive, 32'h1);
        n = 0;
        while (txActive !== 1'b0 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40000) begin
            errorCnt++;
            finishTest();
        end
        // busy drops as the last chip starts: let the receiver take it first
        repeat (700) @(posedge clk);
        chk(32'(expQ.size()), 32'h0);
    endtask
    // ----------------------------------------
    // output watchers
    // ----------------------------------------
    always @(posedge clk) begin
        if (chipValid === 1'b1) chk(chipBit, expQ.size() ? expQ.pop_front() : 1'bx);
        if (avsRead && avsWaitRequest === 1'b0) chk(avsReadData, readQ.pop_front());
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, ook_pkg::REG_CODING, 32'h0008_0e04);
        bus(1'b0, ook_pkg::REG_SYNC, 32'h8000_0000);
        bus(1'b0, ook_pkg::REG_PKT, 32'h0000_0002);
        bus(1'b0, ook_pkg::REG_SIZES, 32'h0400_0820);
        bus(1'b0, ook_pkg::REG_RATE, 32'h0000_1457);
        bus(1'b0, 4'hb, 32'h0); // unmapped word reads zero
        chk(powerStep, 32'hd);
        bus(1'b1, ook_pkg::REG_CTRL, 32'h0000_0070);
        // power output registers one clock after the write lands
        @(posedge clk);
        chk(powerStep, 32'h7);
        bus(1'b1, ook_pkg::REG_RATE, 32'h0000_0270);
        // four-chip pwm, random eight-bit identifier only
        seed = lfsr(seed);
        idVal = {24'h0, seed[7:0] | 8'h80};
        bus(1'b1, ook_pkg::REG_ID, idVal);
        bus(1'b1, ook_pkg::REG_SIZES, 32'h0000_0800);
        bus(1'b1, ook_pkg::REG_PKT, 32'h0000_0001);
        for (int i = 7; i >= 0; i--) push(idVal[i] ? 32'he : 32'h8, 4);
        runTx(32'h0000_00d1, 4'h0);
        // nrz, 0xaa preamble, two ungrouped packets with a three-symbol gap
        bus(1'b1, ook_pkg::REG_CODING, 32'h0000_0101);
        bus(1'b1, ook_pkg::REG_SYNC, 32'h0000_0009);
        bus(1'b1, ook_pkg::REG_ID, 32'h0000_0001);
        bus(1'b1, ook_pkg::REG_STOP, 32'h0000_0001);
        bus(1'b1, ook_pkg::REG_SIZES, 32'h0202_0104);
        bus(1'b1, ook_pkg::REG_PKT, 32'h0001_0002);
        bus(1'b1, ook_pkg::REG_COUNTS, 32'h0000_0003);
        for (int p = 0; p < 2; p++) begin
            if (p) push(32'h0, 3);
            push(32'haa, 8);
            pushTail();
        end
        runTx(32'h0000_00d5, 4'h0);
        // two groups of two, preamble on first packet of each group only, two-symbol group gap
        bus(1'b1, ook_pkg::REG_COUNTS, 32'h0002_0002);
        for (int g = 0; g < 2; g++) begin
            if (g) push(32'h0, 2);
            push(32'haa, 8);
            pushTail();
            pushTail();
        end
        runTx(32'h0000_00dd, 4'h0);
        // matrix scan: row one is taken in column zero, so key one, code 0x02
        bus(1'b1, ook_pkg::REG_SIZES, 32'h0800_0100);
        bus(1'b1, ook_pkg::REG_PKT, 32'h0000_0001);
        bus(1'b1, ook_pkg::REG_COUNTS, 32'h0000_0000);
        push(32'h1, 1);
        push(32'h02, 8);
        runTx(32'h0000_00d2, 4'h2);
        bus(1'b1, ook_pkg::REG_CTRL, 32'h0000_00d0);
        @(posedge clk);
        chk(scanOut, 32'h0);
        finishTest();
    end
endmodule
